// ### acl_cam.sv
// file: connection lookup cam with strobe port, result bus and ahb-lite registers
// Function
// - 4096x32 array, 12-bit result address out
// - one compare searches array and path table
// - config bit enables path-table test
// - path table 4K bits indexed by path field
// - only lowest-priority device reports path hits
// - array match beats path hit; else path value
// - match flag and local hit encode result
// - write at address or next free, show address
// - validity set/clear by address or match
// - clearing validity drives that address out
// - validity line low valid, read drives it
// - strobe high: data bus released, chip idle
// - direction and selects steer data bus
// - hardware mode: select picks address or control
// - software mode ignores address/control bus
// - result bus shows latest cycle's address
// - output enable high floats result outputs
// - cascade: only highest responder drives result
// - total miss or full system: lowest drives ones
// - result latched while strobe low
// - bank number from config, same conditions
// - inputs sampled at strobe falling edge
// - either select low selects the device
// - chained match input low forces flag low
`timescale 1ns/1ps
module acl_cam
	import acl_pkg::*;
#(
	parameter int DEPTH = ACL_DEPTH,
	parameter int WIDTH = ACL_WIDTH,
	parameter int AW = ACL_AW
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// strobe-timed controller port
	input wire logic chip_strobe_n,
	input wire logic dir_n,
	input wire logic select_a_n,
	input wire logic select_b_n,
	input wire logic addr_or_ctrl_sel,
	input wire logic [AW-1:0] addr_ctrl_in,
	input wire logic [WIDTH-1:0] data_io_bus_i,
	output logic [WIDTH-1:0] data_io_bus_o,
	output logic data_io_bus_oe,
	input wire logic entry_valid_io_i,
	output logic entry_valid_io_o,
	output logic entry_valid_io_oe,
	// result bus and cascade
	input wire logic out_en_n,
	input wire logic chain_match_in,
	input wire logic chain_full_n_in,
	output logic [AW-1:0] result_addr_out,
	output logic [ACL_PW-1:0] bank_no_out,
	output logic result_oe,
	output logic match_flag_n,
	output logic local_hit_n
);
	generate
		if (DEPTH != (1 << AW) || WIDTH < ACL_PATH_LSB + AW) begin : g_bad
			$error("acl_cam: DEPTH must be 2**AW and WIDTH hold the path field");
		end
	endgenerate

	// lowest set bit of a vector; found flag in the top bit
	function automatic logic [AW:0] first_set(input logic [DEPTH-1:0] v);
		logic [AW:0] r;
		r = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, AW'(i)};
			end
		end
		return r;
	endfunction

	logic [WIDTH-1:0] cam_mem [DEPTH];
	logic [DEPTH-1:0] valid_reg;
	logic [DEPTH-1:0] path_valid_bitmap;

	logic [31:0] cfg_reg, cfg_next;
	logic [31:0] swcmd_reg, swcmd_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_ofs_reg, wr_ofs_next;

	acl_state_t state_reg, state_next;
	acl_result_t pend_reg, pend_next;
	logic [AW-1:0] res_addr_reg, res_addr_next;
	logic [ACL_PW-1:0] bank_reg, bank_next;
	logic drive_reg, drive_next;
	logic res_oe_reg, res_oe_next;
	logic flag_n_reg, flag_n_next;
	logic hit_n_reg, hit_n_next;
	logic [WIDTH-1:0] dout_reg, dout_next;
	logic doe_reg, doe_next;
	logic vout_reg, vout_next;

	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic vld_we, vld_val;
	logic [AW-1:0] vld_addr;
	logic pt_we;

	logic [DEPTH-1:0] hit_vec;
	logic [AW:0] match_enc, free_enc;
	logic full_local;
	logic fall;
	logic selected;
	logic sw_mode;
	acl_op_t op;
	logic [AW-1:0] op_addr;
	logic [AW-1:0] path_idx;
	logic arr_match, path_hit;

	// whole array compared at once against the bus word
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			hit_vec[i] = valid_reg[i] && (cam_mem[i] == data_io_bus_i);
		end
	end
	assign match_enc = first_set(hit_vec);
	assign free_enc = first_set(~valid_reg);
	assign full_local = ~free_enc[AW];
	assign arr_match = match_enc[AW];
	assign path_idx = data_io_bus_i[ACL_PATH_LSB +: AW];
	// path table only in the lowest-priority device
	assign path_hit = cfg_reg[ACL_CFG_PATH_EN] && cfg_reg[ACL_CFG_LOWEST]
		&& path_valid_bitmap[path_idx];

	assign fall = (state_reg == ACL_ST_HIGH) && !chip_strobe_n;
	assign selected = !select_a_n || !select_b_n;
	assign sw_mode = cfg_reg[ACL_CFG_SW_MODE];

	// operation decode
	always_comb begin
		if (sw_mode) begin
			op = acl_op_t'(swcmd_reg[2:0]);
			op_addr = swcmd_reg[ACL_SW_ADDR_LSB +: AW];
		end else if (addr_or_ctrl_sel) begin
			op = acl_op_t'(addr_ctrl_in[2:0]);
			op_addr = '0;
		end else begin
			op = dir_n ? ACL_OP_READ : ACL_OP_WRITE;
			op_addr = addr_ctrl_in;
		end
	end

	// strobe cycle: sample at falling edge, publish while high
	always_comb begin
		state_next = chip_strobe_n ? ACL_ST_HIGH : ACL_ST_LOW;
		pend_next = pend_reg;
		dout_next = dout_reg;
		vout_next = vout_reg;
		doe_next = doe_reg && !chip_strobe_n;
		mem_we = 1'b0;
		mem_addr = op_addr;
		vld_we = 1'b0;
		vld_val = 1'b0;
		vld_addr = op_addr;
		pt_we = 1'b0;
		if (fall && selected) begin
			case (op)
				ACL_OP_READ: begin
					dout_next = cam_mem[op_addr];
					vout_next = !valid_reg[op_addr];
					// never drive against a controller that is writing
					doe_next = dir_n;
					pend_next.addr = op_addr;
					pend_next.drive = 1'b1;
				end
				ACL_OP_WRITE: begin
					mem_we = 1'b1;
					vld_we = 1'b1;
					vld_val = !entry_valid_io_i;
					pend_next.addr = op_addr;
					pend_next.drive = 1'b1;
				end
				ACL_OP_VLD_ADDR: begin
					vld_we = 1'b1;
					vld_val = !entry_valid_io_i;
					pend_next.addr = op_addr;
					pend_next.drive = 1'b1;
				end
				ACL_OP_COMPARE: begin
					// a higher device's match silences this one
					pend_next.flag_n = !(arr_match || !chain_match_in);
					pend_next.hit_n = !(arr_match || path_hit);
					if (!chain_match_in) begin
						pend_next.drive = 1'b0;
					end else if (arr_match) begin
						pend_next.addr = match_enc[AW-1:0];
						pend_next.drive = 1'b1;
					end else if (path_hit) begin
						pend_next.addr = path_idx;
						pend_next.drive = 1'b1;
					end else begin
						pend_next.addr = '1;
						pend_next.drive = cfg_reg[ACL_CFG_LOWEST];
					end
				end
				ACL_OP_WR_FREE: begin
					// higher devices must all be full first
					if (!chain_full_n_in && !full_local) begin
						mem_we = 1'b1;
						mem_addr = free_enc[AW-1:0];
						vld_we = 1'b1;
						vld_val = 1'b1;
						vld_addr = free_enc[AW-1:0];
						pend_next.addr = free_enc[AW-1:0];
						pend_next.drive = 1'b1;
					end else begin
						pend_next.addr = '1;
						pend_next.drive = !chain_full_n_in && cfg_reg[ACL_CFG_LOWEST];
					end
				end
				ACL_OP_VLD_MATCH, ACL_OP_EMPTY_MATCH: begin
					if (chain_match_in && arr_match) begin
						vld_we = 1'b1;
						vld_val = (op == ACL_OP_VLD_MATCH);
						vld_addr = match_enc[AW-1:0];
						pend_next.addr = match_enc[AW-1:0];
						pend_next.drive = 1'b1;
					end else begin
						pend_next.drive = 1'b0;
					end
				end
				ACL_OP_PATH_WR: begin
					pt_we = 1'b1;
				end
				default: begin
					pend_next = pend_reg;
				end
			endcase
		end
	end

	// result bus: held while strobe low, follows pending while high
	always_comb begin
		res_addr_next = res_addr_reg;
		bank_next = bank_reg;
		drive_next = drive_reg;
		flag_n_next = flag_n_reg;
		hit_n_next = hit_n_reg;
		if (chip_strobe_n) begin
			res_addr_next = pend_reg.addr;
			bank_next = cfg_reg[ACL_CFG_PAGE_LSB +: ACL_PW];
			drive_next = pend_reg.drive;
			flag_n_next = pend_reg.flag_n;
			hit_n_next = pend_reg.hit_n;
		end
		res_oe_next = !out_en_n && drive_next;
	end

	// ahb-lite slave, zero wait states, always okay
	always_comb begin
		cfg_next = cfg_reg;
		swcmd_next = swcmd_reg;
		hrdata_next = hrdata_reg;
		wr_pend_next = 1'b0;
		wr_ofs_next = wr_ofs_reg;
		if (wr_pend_reg) begin
			case (wr_ofs_reg)
				ACL_CFG_OFS: cfg_next = hwdata;
				ACL_SWCMD_OFS: swcmd_next = hwdata;
				default: cfg_next = cfg_reg;
			endcase
		end
		if (hsel && hready && htrans == ACL_HTRANS_NONSEQ) begin
			wr_pend_next = hwrite;
			wr_ofs_next = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					ACL_CFG_OFS: hrdata_next = cfg_reg;
					ACL_SWCMD_OFS: hrdata_next = swcmd_reg;
					ACL_STAT_OFS: begin
						hrdata_next = '0;
						hrdata_next[ACL_ST_FLAG] = flag_n_reg;
						hrdata_next[ACL_ST_HIT] = hit_n_reg;
						hrdata_next[ACL_ST_FULL] = full_local;
						hrdata_next[ACL_ST_ADDR_LSB +: AW] = res_addr_reg;
					end
					default: hrdata_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= ACL_CFG_RST;
			swcmd_reg <= ACL_SWCMD_RST;
			hrdata_reg <= '0;
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= '0;
			state_reg <= ACL_ST_HIGH;
			pend_reg <= '{addr: '1, drive: 1'b0, flag_n: 1'b1, hit_n: 1'b1};
			res_addr_reg <= '1;
			bank_reg <= '0;
			drive_reg <= 1'b0;
			res_oe_reg <= 1'b0;
			flag_n_reg <= 1'b1;
			hit_n_reg <= 1'b1;
			dout_reg <= '0;
			doe_reg <= 1'b0;
			vout_reg <= 1'b1;
			valid_reg <= '0;
			path_valid_bitmap <= '0;
		end else if (clk_en) begin
			cfg_reg <= cfg_next;
			swcmd_reg <= swcmd_next;
			hrdata_reg <= hrdata_next;
			wr_pend_reg <= wr_pend_next;
			wr_ofs_reg <= wr_ofs_next;
			state_reg <= state_next;
			pend_reg <= pend_next;
			res_addr_reg <= res_addr_next;
			bank_reg <= bank_next;
			drive_reg <= drive_next;
			res_oe_reg <= res_oe_next;
			flag_n_reg <= flag_n_next;
			hit_n_reg <= hit_n_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
			vout_reg <= vout_next;
			if (vld_we) begin
				valid_reg[vld_addr] <= vld_val;
			end
			if (pt_we) begin
				// low data bit carries the table bit to store
				path_valid_bitmap[path_idx] <= data_io_bus_i[0];
			end
		end
	end

	// array contents need no reset; validity bits gate every compare, reads return raw contents with the validity bit
	always_ff @(posedge hclk) begin
		if (clk_en && mem_we) begin
			cam_mem[mem_addr] <= data_io_bus_i;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign data_io_bus_o = dout_reg;
	assign data_io_bus_oe = doe_reg;
	assign entry_valid_io_o = vout_reg;
	assign entry_valid_io_oe = doe_reg;
	assign result_addr_out = res_addr_reg;
	assign bank_no_out = bank_reg;
	assign result_oe = res_oe_reg;
	assign match_flag_n = flag_n_reg;
	assign local_hit_n = hit_n_reg;
endmodule

// ### acl_pkg.sv
// package: constants, types and register map of the connection lookup cam
package acl_pkg;
	localparam int ACL_DEPTH = 4096;
	localparam int ACL_WIDTH = 32;
	localparam int ACL_AW = 12;
	localparam int ACL_PW = 4;
	localparam int ACL_PATH_LSB = 16;
	// ahb register offsets (byte addresses)
	localparam logic [7:0] ACL_CFG_OFS = 8'h00;
	localparam logic [7:0] ACL_STAT_OFS = 8'h04;
	localparam logic [7:0] ACL_SWCMD_OFS = 8'h08;
	// configuration fields
	localparam int ACL_CFG_PATH_EN = 0;
	localparam int ACL_CFG_SW_MODE = 1;
	localparam int ACL_CFG_LOWEST = 2;
	localparam int ACL_CFG_PAGE_LSB = 4;
	localparam logic [31:0] ACL_CFG_RST = 32'h0000_0004;
	// status fields
	localparam int ACL_ST_FLAG = 0;
	localparam int ACL_ST_HIT = 1;
	localparam int ACL_ST_FULL = 2;
	localparam int ACL_ST_ADDR_LSB = 16;
	// software command fields
	localparam int ACL_SW_ADDR_LSB = 16;
	localparam logic [31:0] ACL_SWCMD_RST = 32'h0000_0000;
	localparam logic [1:0] ACL_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		ACL_OP_READ = 3'h0,
		ACL_OP_WRITE = 3'h1,
		ACL_OP_COMPARE = 3'h2,
		ACL_OP_WR_FREE = 3'h3,
		ACL_OP_VLD_MATCH = 3'h4,
		ACL_OP_EMPTY_MATCH = 3'h5,
		ACL_OP_VLD_ADDR = 3'h6,
		ACL_OP_PATH_WR = 3'h7
	} acl_op_t;
	typedef enum logic [1:0] {
		ACL_ST_HIGH = 2'b00,
		ACL_ST_LOW = 2'b01
	} acl_state_t;
	typedef struct packed {
		logic [ACL_AW-1:0] addr;
		logic drive;
		logic flag_n;
		logic hit_n;
	} acl_result_t;
endpackage

// ### acl_cam_chk.sv
// checker: port timing relations of the connection lookup cam
`timescale 1ns/1ps
module acl_cam_chk #(
	parameter int AW = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic chip_strobe_n,
	input wire logic dir_n,
	input wire logic select_a_n,
	input wire logic select_b_n,
	input wire logic out_en_n,
	input wire logic chain_match_in,
	input wire logic data_io_bus_oe,
	input wire logic entry_valid_io_oe,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [AW-1:0] result_addr_out,
	input wire logic [3:0] bank_no_out,
	input wire logic result_oe,
	input wire logic match_flag_n,
	input wire logic local_hit_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	result_hold_a: assert property (!$past(chip_strobe_n) |->
		$stable({result_addr_out, bank_no_out, match_flag_n, local_hit_n}))
		else $error("result bus moved while strobe low");
	result_update_a: assert property ($changed(result_addr_out) |->
		$past(chip_strobe_n) && !$past(chip_strobe_n, 2))
		else $error("result address changed outside strobe rise");
	result_float_a: assert property ($past(out_en_n) |-> !result_oe)
		else $error("result driven while output enable high");
	flag_code_a: assert property ($changed({match_flag_n, local_hit_n}) && !match_flag_n
		&& chain_match_in |-> !local_hit_n)
		else $error("array match without local hit");
	bus_release_a: assert property ($past(chip_strobe_n) |-> !data_io_bus_oe)
		else $error("data bus driven while strobe high");
	read_dir_a: assert property (data_io_bus_oe |-> dir_n)
		else $error("data bus driven during a write");
	valid_pin_a: assert property (entry_valid_io_oe == data_io_bus_oe)
		else $error("validity pin enable differs from data enable");
	select_gate_a: assert property (data_io_bus_oe |-> !(select_a_n && select_b_n))
		else $error("data bus driven while deselected");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus slave waited or erred");
	cover property (!match_flag_n);
	cover property (match_flag_n && !local_hit_n);
	cover property (data_io_bus_oe);
	cover property (!match_flag_n && local_hit_n);
endmodule
bind acl_cam acl_cam_chk #(.AW(AW)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.chip_strobe_n(chip_strobe_n), .dir_n(dir_n), .select_a_n(select_a_n),
	.select_b_n(select_b_n), .out_en_n(out_en_n), .chain_match_in(chain_match_in),
	.data_io_bus_oe(data_io_bus_oe), .entry_valid_io_oe(entry_valid_io_oe),
	.hreadyout(hreadyout), .hresp(hresp), .result_addr_out(result_addr_out),
	.bank_no_out(bank_no_out), .result_oe(result_oe), .match_flag_n(match_flag_n),
	.local_hit_n(local_hit_n));

// ### acl_ctl_model.sv
// partner: switch controller driving the strobe port
`timescale 1ns/1ps
module acl_ctl_model (
	input wire logic hclk,
	input wire logic [31:0] d_o,
	input wire logic d_oe,
	input wire logic v_o,
	output logic strobe_n,
	output logic dir_n,
	output logic sa_n,
	output logic sb_n,
	output logic aoc,
	output logic [11:0] addr_ctrl,
	output logic [31:0] d_bus,
	output logic v_bus
);
	logic drive = 1'b0;
	logic [31:0] d_drv = 32'h0;
	logic v_drv = 1'b1;
	initial begin
		strobe_n = 1'b1;
		dir_n = 1'b1;
		sa_n = 1'b1;
		sb_n = 1'b1;
		aoc = 1'b0;
		addr_ctrl = 12'h000;
	end
	// released lines show the inverse of the last value; contention shows x
	assign d_bus = d_oe ? (drive ? 'x : d_o) : d_drv;
	assign v_bus = d_oe ? (drive ? 1'bx : v_o) : v_drv;
	task automatic op(input logic s, input logic w_n, input logic [11:0] a,
		input logic [31:0] d, input logic v, input logic cs_n,
		output logic [31:0] rd, output logic rv);
		@(posedge hclk);
		// all qualifiers held through the low pulse
		aoc <= s;
		dir_n <= w_n;
		addr_ctrl <= a;
		sa_n <= cs_n;
		d_drv <= d;
		v_drv <= v;
		drive <= !w_n;
		strobe_n <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		rd = d_bus;
		rv = v_bus;
		@(posedge hclk);
		strobe_n <= 1'b1;
		drive <= 1'b0;
		d_drv <= ~d;
		v_drv <= ~v;
		repeat (3) @(posedge hclk);
		#1;
	endtask
endmodule

// ### test_atm_connection_lookup_cam.sv
// testbench: scenarios for the connection lookup cam
`timescale 1ns/1ps
module test_atm_connection_lookup_cam;
	import acl_pkg::*;
	localparam logic [31:0] DA = 32'h0ABC_0001;
	localparam logic [31:0] DB = 32'h0ABC_0002;
	localparam logic [31:0] DC = 32'h0123_0005;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic out_en_n = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd, d_o, d_bus;
	logic hreadyout, hresp, rv, strobe_n, dir_n, sa_n, sb_n, aoc, d_oe, v_o, v_oe, v_bus;
	logic r_oe, flag_n, hit_n;
	logic chain_match_in = 1'b1;
	logic chain_full_n_in = 1'b0;
	logic [11:0] addr_ctrl, res;
	logic [3:0] bank;
	int fails = 0;
	int comparisons = 0;
	always #5 hclk = ~hclk;
	acl_cam i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.chip_strobe_n(strobe_n), .dir_n(dir_n), .select_a_n(sa_n), .select_b_n(sb_n),
		.addr_or_ctrl_sel(aoc), .addr_ctrl_in(addr_ctrl), .data_io_bus_i(d_bus),
		.data_io_bus_o(d_o), .data_io_bus_oe(d_oe), .entry_valid_io_i(v_bus),
		.entry_valid_io_o(v_o), .entry_valid_io_oe(v_oe), .out_en_n(out_en_n),
		.chain_match_in(chain_match_in), .chain_full_n_in(chain_full_n_in),
		.result_addr_out(res), .bank_no_out(bank), .result_oe(r_oe), .match_flag_n(flag_n),
		.local_hit_n(hit_n));
	acl_ctl_model i_ctl (.hclk(hclk), .d_o(d_o), .d_oe(d_oe), .v_o(v_o),
		.strobe_n(strobe_n), .dir_n(dir_n), .sa_n(sa_n), .sb_n(sb_n), .aoc(aoc),
		.addr_ctrl(addr_ctrl), .d_bus(d_bus), .v_bus(v_bus));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= ACL_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cmp(input logic [31:0] d);
		i_ctl.op(1'b1, 1'b0, 12'h002, d, 1'b1, 1'b0, rd, rv);
	endtask
	task automatic t_reset;
		check("reset result", res, 32'hFFF);
		check("reset flags", {flag_n, hit_n}, 32'h3);
		ahb(1'b0, {24'h0, ACL_CFG_OFS}, 32'h0);
		check("cfg reset", rd, ACL_CFG_RST);
	endtask
	task automatic t_write_cmp;
		i_ctl.op(1'b1, 1'b0, 12'h003, DA, 1'b0, 1'b0, rd, rv);
		check("free write addr", res, 32'h0);
		check("oe high floats", r_oe, 32'h0);
		@(posedge hclk);
		out_en_n <= 1'b0;
		i_ctl.op(1'b0, 1'b0, 12'h007, DB, 1'b0, 1'b0, rd, rv);
		check("addr write", res, 32'h7);
		check("oe low drives", r_oe, 32'h1);
		i_ctl.op(1'b0, 1'b0, 12'h009, DB, 1'b0, 1'b0, rd, rv);
		cmp(DB);
		check("lowest match", res, 32'h7);
		check("match flags", {flag_n, hit_n}, 32'h0);
		cmp(DA);
		check("match other", res, 32'h0);
	endtask
	task automatic t_read_clear;
		i_ctl.op(1'b0, 1'b1, 12'h007, 32'h0, 1'b1, 1'b0, rd, rv);
		check("read data", rd, DB);
		check("read validity", rv, 32'h0);
		check("read addr", res, 32'h7);
		i_ctl.op(1'b1, 1'b0, 12'h005, DB, 1'b1, 1'b0, rd, rv);
		check("cleared addr", res, 32'h7);
		cmp(DB);
		check("next match", res, 32'h9);
		i_ctl.op(1'b0, 1'b0, 12'h00B, DA, 1'b0, 1'b1, rd, rv);
		check("deselected", res, 32'h9);
	endtask
	task automatic t_path;
		// table bit set while the test is still off, so the miss proves the gate
		i_ctl.op(1'b1, 1'b0, 12'h007, 32'h0123_0001, 1'b1, 1'b0, rd, rv);
		cmp(DC);
		check("miss addr", res, 32'hFFF);
		check("miss driven", r_oe, 32'h1);
		check("miss flags", {flag_n, hit_n}, 32'h3);
		ahb(1'b1, {24'h0, ACL_CFG_OFS}, 32'h0000_0055);
		cmp(DC);
		check("path addr", res, 32'h123);
		check("path flags", {flag_n, hit_n}, 32'h2);
		check("bank", bank, 32'h5);
		ahb(1'b0, {24'h0, ACL_STAT_OFS}, 32'h0);
		check("status addr", rd[27:16], 32'h123);
		ahb(1'b0, 32'h0000_000C, 32'h0);
		check("unmapped", rd, 32'h0);
		ahb(1'b1, {24'h0, ACL_CFG_OFS}, 32'h0000_0057);
		ahb(1'b1, {24'h0, ACL_SWCMD_OFS}, 32'h0000_0002);
		i_ctl.op(1'b1, 1'b0, 12'h001, DB, 1'b1, 1'b0, rd, rv);
		check("soft compare", res, 32'h9);
	endtask
	task automatic t_cascade;
		// path test on, but this device now sits above the lowest one
		ahb(1'b1, {24'h0, ACL_CFG_OFS}, 32'h0000_0051);
		cmp(DC);
		check("upper no path", {flag_n, hit_n}, 32'h3);
		check("upper silent", r_oe, 32'h0);
		@(posedge hclk);
		chain_match_in <= 1'b0;
		cmp(DC);
		check("chain forced", {flag_n, hit_n}, 32'h1);
		check("chain silent", r_oe, 32'h0);
		@(posedge hclk);
		chain_match_in <= 1'b1;
		chain_full_n_in <= 1'b1;
		i_ctl.op(1'b1, 1'b0, 12'h003, DC, 1'b0, 1'b0, rd, rv);
		check("free blocked", r_oe, 32'h0);
		@(posedge hclk);
		chain_full_n_in <= 1'b0;
		// a blocked write that landed would push this one past index 1
		i_ctl.op(1'b1, 1'b0, 12'h003, DC, 1'b0, 1'b0, rd, rv);
		check("free after block", res, 32'h1);
		check("free driven", r_oe, 32'h1);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_write_cmp;
		t_read_clear;
		t_path;
		t_cascade;
		tally_and_finish;
	end
endmodule
